/* File: rtl/dsss_pkg.sv */
// Purpose: Shared constants and types of the drive safe stop supervisor
// Assumes: 25 MHz reference clock, 32-bit register port, byte addresses
// Notes: Interval values are counted in hundredths of an hour
`default_nettype none
package dsss_pkg;
  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int MON_CYCLE_US = 4000;
  // Least time, so round up
  localparam int MON_CYCLE_CYC = (MON_CYCLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CENTIHOUR_MS = 36000;
  // Monitoring cycles per hundredth of an hour
  localparam int CENTIHOUR_TICKS = (CENTIHOUR_MS * 1000) / MON_CYCLE_US;

  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_CU_EN = 8'h08;
  localparam logic [7:0] ADDR_PM_EN = 8'h0c;
  localparam logic [7:0] ADDR_FTI = 8'h10;
  localparam logic [7:0] ADDR_CU_REF = 8'h14;
  localparam logic [7:0] ADDR_PM_REF = 8'h18;
  localparam logic [7:0] ADDR_CU_ACT = 8'h1c;
  localparam logic [7:0] ADDR_PM_ACT = 8'h20;
  localparam logic [7:0] ADDR_PW_ENTRY = 8'h24;
  localparam logic [7:0] ADDR_PW_NEW = 8'h28;
  localparam logic [7:0] ADDR_PW_CONFIRM = 8'h2c;
  localparam logic [7:0] ADDR_CMD = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  localparam logic [7:0] ADDR_VERSION = 8'h38;
  localparam logic [7:0] ADDR_TIMER = 8'h3c;

  // ********************************
  // Field positions and codes
  // ********************************
  localparam int CTRL_PARK_BIT = 0;
  localparam int CMD_ADOPT_BIT = 0;
  localparam int CMD_DRV_RESET_BIT = 1;
  localparam int CMD_QC_FINISH_BIT = 2;
  localparam int CMD_UNIT_RESTORE_BIT = 3;
  localparam int EN_CUTOFF_BIT = 0;
  localparam logic [7:0] MODE_SAFETY = 8'h5f;
  localparam logic [7:0] UNIT_RESTORE = 8'h1e;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [19:0] FTI_DEFAULT = 20'h00320;
  localparam logic [19:0] FTI_MAX = 20'hdbba0;
  localparam logic [15:0] PW_DEFAULT = 16'h0000;
  localparam logic [15:0] REF_DEFAULT = 16'h0000;
  localparam logic [7:0] EN_DEFAULT = 8'h00;

  // ********************************
  // Types
  // ********************************
  // One channel's copy of the safety parameters
  typedef struct packed {
    logic [7:0] enable;
    logic [19:0] interval;
  } dsss_chan_type;

  localparam dsss_chan_type CHAN_DEFAULT = '{enable: EN_DEFAULT, interval: FTI_DEFAULT};

  // Status word, low bits of the status register
  typedef struct packed {
    logic brake_close;
    logic wr_ok;
    logic boot_done;
    logic accept_req;
    logic pm_fault;
    logic cu_fault;
    logic test_due;
    logic lockout;
    logic cutoff;
  } dsss_status_type;

  typedef enum logic [1:0] {B_CLR, B_FEED, B_CHK, B_RUN} dsss_boot_type;
endpackage
`default_nettype wire

/* File: rtl/dsss_crc.sv */
// Purpose: Word-parallel CRC-16 over 32-bit words of one channel
// Assumes: Caller clears it before the first word
// Notes: Result holds once feeding stops
`default_nettype none
module dsss_crc
  import dsss_pkg::*;
(
  input wire logic ref_clk_i, // Clock
  input wire logic srst_i, // Sync reset
  input wire logic clr_i, // Load initial value
  input wire logic en_i, // Absorb data word
  input wire logic [31:0] data_i, // Data word
  output logic [15:0] crc_o // Running checksum
);
  // ********************************
  // Word step
  // ********************************
  // Whole word per cycle, MSB first
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  logic [15:0] crc_q; // Accumulator
  logic [15:0] crc_d; // Next value

  // Next value
  always_comb begin
    crc_d = crc_q;
    if (clr_i) begin
      crc_d = CRC_INIT;
    end else if (en_i) begin
      crc_d = crc_word(crc_q, data_i);
    end
  end

  // Register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;
endmodule
`default_nettype wire

/* File: rtl/dsss_top.sv */
// Purpose: Safety supervisor of one drive: cutoff, checksum, password, test timer
// Assumes: Shutdown select pins are asynchronous and active low
// Notes: Cutoff and timer advance once per monitoring cycle
`default_nettype none
module dsss_top
  import dsss_pkg::*;
#(
  parameter int MON_CYC = MON_CYCLE_CYC, // Clocks per monitoring cycle
  parameter int CH_TICKS = CENTIHOUR_TICKS, // Cycles per 0.01 h
  parameter logic [15:0] CU_VER = 16'h0001, // Arbitrary value
  parameter logic [15:0] PM_VER = 16'h0002 // Arbitrary value
) (
  input wire logic ref_clk_i, // Clock
  input wire logic srst_i, // Sync reset
  input wire logic [7:0] addr_i, // Byte address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [31:0] rd_data_o, // Read data, next cycle
  input wire logic sel_cu_n_i, // CU select pin, low
  input wire logic sel_pm_n_i, // PM select pin, low
  input wire logic drive_on_i, // Drive enable pin
  input wire logic chassis_i, // Chassis power unit
  output logic shutdown_cu_n_o, // CU path, low cuts
  output logic shutdown_pm_n_o, // PM path, low cuts
  output logic restart_lockout_o, // Restart inhibit
  output logic brake_close_o, // Holding brake apply
  output logic test_due_o, // Test-due alarm
  output logic [1:0] cks_fault_o, // PM, CU mismatch
  output logic accept_test_o, // Acceptance test request
  output logic boot_done_o // Startup check finished
);
  localparam int MW = $clog2(MON_CYC + 1);
  localparam int CW = $clog2(CH_TICKS + 1);

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [2:0] s1_q; // First stage only
  logic [2:0] s2_q; // Safe to read

  // Two stages, reset to selected
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {drive_on_i, sel_pm_n_i, sel_cu_n_i};
      s2_q <= s1_q;
    end
  end

  // ********************************
  // Parameters and password
  // ********************************
  dsss_chan_type cu_q, cu_d; // CU copy
  dsss_chan_type pm_q, pm_d; // PM copy
  logic [15:0] cref_q, cref_d; // CU reference
  logic [15:0] pref_q, pref_d; // PM reference
  logic [15:0] pws_q, pws_d; // Stored password
  logic [15:0] pwe_q, pwe_d; // Password entry
  logic [15:0] pwn_q, pwn_d; // New password
  logic [15:0] pwc_q, pwc_d; // Confirmation
  logic [7:0] mode_q, mode_d; // Commissioning mode
  logic [7:0] unit_q, unit_d; // Unit commission select
  logic park_q, park_d; // Parking mode
  logic [7:0] rej_q, rej_d; // Rejection counter
  logic [15:0] cu_crc; // CU actual checksum
  logic [15:0] pm_crc; // PM actual checksum
  logic wr_ok; // Protected write allowed
  logic prot; // Address is protected
  logic adopt; // Adopt accepted
  logic drv_rst; // Drive reset requested
  logic safe_off; // Both enables zero

  assign wr_ok = (mode_q == MODE_SAFETY) && (pwe_q == pws_q);
  assign prot = (addr_i == ADDR_CU_EN) || (addr_i == ADDR_PM_EN) || (addr_i == ADDR_FTI) ||
                (addr_i == ADDR_CU_REF) || (addr_i == ADDR_PM_REF);
  assign adopt = wr_i && (addr_i == ADDR_CMD) && wdata_i[CMD_ADOPT_BIT] && wr_ok;
  assign drv_rst = wr_i && (addr_i == ADDR_CMD) && (wdata_i[CMD_DRV_RESET_BIT] || wdata_i[CMD_QC_FINISH_BIT]);
  assign safe_off = (cu_q.enable == EN_DEFAULT) && (pm_q.enable == EN_DEFAULT);

  // Register writes and commands
  always_comb begin
    cu_d = cu_q;
    pm_d = pm_q;
    cref_d = cref_q;
    pref_d = pref_q;
    pws_d = pws_q;
    pwe_d = pwe_q;
    pwn_d = pwn_q;
    pwc_d = pwc_q;
    mode_d = mode_q;
    unit_d = unit_q;
    park_d = park_q;
    rej_d = rej_q;
    if (wr_i && prot && !wr_ok) begin
      rej_d = rej_q + 8'h01;
    end else if (wr_i) begin
      unique case (addr_i)
        ADDR_CTRL: park_d = wdata_i[CTRL_PARK_BIT];
        ADDR_MODE: begin
          mode_d = wdata_i[7:0];
          unit_d = wdata_i[15:8];
        end
        ADDR_CU_EN: cu_d.enable = wdata_i[7:0];
        ADDR_PM_EN: pm_d.enable = wdata_i[7:0];
        ADDR_FTI: begin
          cu_d.interval = (wdata_i[19:0] > FTI_MAX || |wdata_i[31:20]) ? FTI_MAX : wdata_i[19:0];
          pm_d.interval = cu_d.interval;
        end
        ADDR_CU_REF: cref_d = wdata_i[15:0];
        ADDR_PM_REF: pref_d = wdata_i[15:0];
        ADDR_PW_ENTRY: pwe_d = wdata_i[15:0];
        ADDR_PW_NEW: pwn_d = wdata_i[15:0];
        ADDR_PW_CONFIRM: begin
          pwc_d = wdata_i[15:0];
          if (wr_ok && (pwn_q == wdata_i[15:0])) begin
            pws_d = pwn_q;
            pwe_d = pwn_q;
          end
        end
        ADDR_CMD: begin
          if (adopt) begin
            cref_d = cu_crc;
            pref_d = pm_crc;
          end else if (wdata_i[CMD_ADOPT_BIT]) begin
            rej_d = rej_q + 8'h01;
          end
          if (drv_rst && safe_off) begin
            cu_d = CHAN_DEFAULT;
            pm_d = CHAN_DEFAULT;
          end else if (drv_rst) begin
            rej_d = rej_q + 8'h01;
          end
          if (wdata_i[CMD_UNIT_RESTORE_BIT] && (unit_q == UNIT_RESTORE)) begin
            cu_d = CHAN_DEFAULT;
            pm_d = CHAN_DEFAULT;
            cref_d = REF_DEFAULT;
            pref_d = REF_DEFAULT;
            pws_d = PW_DEFAULT;
            pwe_d = PW_DEFAULT;
          end else if (wdata_i[CMD_UNIT_RESTORE_BIT]) begin
            rej_d = rej_q + 8'h01;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Register; password starts at zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cu_q <= CHAN_DEFAULT;
      pm_q <= CHAN_DEFAULT;
      cref_q <= REF_DEFAULT;
      pref_q <= REF_DEFAULT;
      pws_q <= PW_DEFAULT;
      pwe_q <= PW_DEFAULT;
      pwn_q <= PW_DEFAULT;
      pwc_q <= PW_DEFAULT;
      mode_q <= 8'h00;
      unit_q <= 8'h00;
      park_q <= 1'b0;
      rej_q <= 8'h00;
    end else begin
      cu_q <= cu_d;
      pm_q <= pm_d;
      cref_q <= cref_d;
      pref_q <= pref_d;
      pws_q <= pws_d;
      pwe_q <= pwe_d;
      pwn_q <= pwn_d;
      pwc_q <= pwc_d;
      mode_q <= mode_d;
      unit_q <= unit_d;
      park_q <= park_d;
      rej_q <= rej_d;
    end
  end

  // ********************************
  // Startup checksum
  // ********************************
  dsss_boot_type st_q, st_d; // Boot state
  logic idx_q, idx_d; // Word index
  logic [1:0] flt_q, flt_d; // PM, CU faults
  logic acc_q, acc_d; // Acceptance request

  // Display values stay out of the sum
  function automatic logic [31:0] chan_word(input dsss_chan_type c, input logic i);
    return i ? {12'h000, c.interval} : {24'h000000, c.enable};
  endfunction

  dsss_crc u_cu_crc (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .clr_i(st_q == B_CLR),
    .en_i(st_q == B_FEED),
    .data_i(chan_word(cu_q, idx_q)),
    .crc_o(cu_crc)
  );
  dsss_crc u_pm_crc (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .clr_i(st_q == B_CLR),
    .en_i(st_q == B_FEED),
    .data_i(chan_word(pm_q, idx_q)),
    .crc_o(pm_crc)
  );

  // Boot sequence and fault flags
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    flt_d = flt_q;
    acc_d = acc_q;
    unique case (st_q)
      B_CLR: st_d = B_FEED;
      B_FEED: begin
        idx_d = ~idx_q;
        if (idx_q) begin
          st_d = B_CHK;
        end
      end
      B_CHK: begin
        flt_d = {pm_crc != pref_q, cu_crc != cref_q};
        acc_d = (pm_crc != pref_q) || (cu_crc != cref_q);
        st_d = B_RUN;
      end
      B_RUN: begin
        if (adopt) begin
          flt_d = 2'h0;
          acc_d = 1'b0;
        end
      end
    endcase
  end

  // Register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q <= B_CLR;
      idx_q <= 1'b0;
      flt_q <= 2'h0;
      acc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      flt_q <= flt_d;
      acc_q <= acc_d;
    end
  end

  // ********************************
  // Cutoff and test timer
  // ********************************
  logic [MW-1:0] mon_q, mon_d; // Cycle divider
  logic [CW-1:0] ch_q, ch_d; // Ticks in 0.01 h
  logic [19:0] tmr_q, tmr_d; // Remaining 0.01 h
  logic cut_q, cut_d; // Cutoff active
  logic lock_q, lock_d; // Restart lockout
  logic due_q, due_d; // Test due
  logic brk_q; // Brake drive present
  logic tick; // Monitoring cycle
  logic fall; // Cutoff deselected
  logic cut_nx; // Cutoff wanted at next tick

  assign tick = mon_q == MW'(MON_CYC - 1);
  assign cut_nx = (st_q != B_RUN) || ((cu_q.enable[EN_CUTOFF_BIT] || pm_q.enable[EN_CUTOFF_BIT]) &&
                  (!s2_q[0] || !s2_q[1] || park_q));
  // Kept off cut_d so the timer block forms no loop
  assign fall = tick && cut_q && !cut_nx;

  // Evaluated once per monitoring cycle
  always_comb begin
    mon_d = tick ? '0 : MW'(mon_q + 1'b1);
    ch_d = ch_q;
    tmr_d = tmr_q;
    cut_d = cut_q;
    lock_d = lock_q;
    due_d = due_q;
    if (tick) begin
      cut_d = cut_nx;
      lock_d = cut_d || (lock_q && s2_q[2]);
      ch_d = (ch_q == CW'(CH_TICKS - 1)) ? '0 : CW'(ch_q + 1'b1);
      if ((ch_q == CW'(CH_TICKS - 1)) && (tmr_q != 20'h00000)) begin
        tmr_d = tmr_q - 20'h00001;
      end
      due_d = due_q || (tmr_q == 20'h00000);
    end
    if (fall) begin
      ch_d = '0;
      tmr_d = cu_q.interval;
      due_d = 1'b0;
    end
  end

  // Register; starts in the safe state
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mon_q <= '0;
      ch_q <= '0;
      tmr_q <= FTI_DEFAULT;
      cut_q <= 1'b1;
      lock_q <= 1'b1;
      due_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      mon_q <= mon_d;
      ch_q <= ch_d;
      tmr_q <= tmr_d;
      cut_q <= cut_d;
      lock_q <= lock_d;
      due_q <= due_d;
      brk_q <= !chassis_i;
    end
  end

  assign shutdown_cu_n_o = !cut_q;
  assign shutdown_pm_n_o = !cut_q;
  assign restart_lockout_o = lock_q;
  assign brake_close_o = cut_q && brk_q;
  assign test_due_o = due_q;
  assign cks_fault_o = flt_q;
  assign accept_test_o = acc_q;
  assign boot_done_o = st_q == B_RUN;

  // ********************************
  // Read port
  // ********************************
  dsss_status_type sts; // Status word
  logic [31:0] rd_q, rd_d; // Read data

  assign sts = '{brake_close: brake_close_o, wr_ok: wr_ok, boot_done: boot_done_o, accept_req: acc_q,
                 pm_fault: flt_q[1], cu_fault: flt_q[0], test_due: due_q, lockout: lock_q, cutoff: cut_q};

  // Unmapped and password words read zero
  always_comb begin
    rd_d = 32'h00000000;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL: rd_d = {31'h00000000, park_q};
        ADDR_MODE: rd_d = {16'h0000, unit_q, mode_q};
        ADDR_CU_EN: rd_d = {24'h000000, cu_q.enable};
        ADDR_PM_EN: rd_d = {24'h000000, pm_q.enable};
        ADDR_FTI: rd_d = {12'h000, cu_q.interval};
        ADDR_CU_REF: rd_d = {16'h0000, cref_q};
        ADDR_PM_REF: rd_d = {16'h0000, pref_q};
        ADDR_CU_ACT: rd_d = {16'h0000, cu_crc};
        ADDR_PM_ACT: rd_d = {16'h0000, pm_crc};
        ADDR_STATUS: rd_d = {8'h00, rej_q, 7'h00, sts};
        ADDR_VERSION: rd_d = {PM_VER, CU_VER};
        ADDR_TIMER: rd_d = {12'h000, tmr_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // Register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_q <= 32'h00000000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data_o = rd_q;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  AST_PARK_CUTOFF: assert property (tick && st_q == B_RUN && park_q && cu_q.enable[0] |=> cut_q)
    else $error("park mode did not cut torque");
  AST_PATHS_LOW: assert property (cut_q |-> !shutdown_cu_n_o && !shutdown_pm_n_o && lock_q)
    else $error("cutoff without both paths low");
  AST_MISMATCH: assert property (st_q == B_CHK && cu_crc != cref_q |=> flt_q[0] && acc_q)
    else $error("checksum mismatch not flagged");
  AST_ADOPT: assert property (adopt |=> cref_q == $past(cu_crc) && pref_q == $past(pm_crc))
    else $error("adopt did not copy checksums");
  AST_DRV_RST: assert property (drv_rst && !safe_off && !wdata_i[3] |=> $stable(cu_q) && $stable(pm_q))
    else $error("drive reset accepted while enabled");
  AST_RESTORE: assert property (wr_i && addr_i == ADDR_CMD && wdata_i[3] && unit_q == UNIT_RESTORE
    |=> pws_q == PW_DEFAULT && cu_q == CHAN_DEFAULT)
    else $error("unit restore not applied");
  AST_PW_GATE: assert property (wr_i && prot && !wr_ok |=> $stable(cu_q) && $stable(cref_q) && $stable(pref_q))
    else $error("protected write passed gate");
  AST_PW_CHANGE: assert property (wr_i && addr_i == ADDR_PW_CONFIRM && wr_ok && pwn_q == wdata_i[15:0]
    |=> pws_q == $past(pwn_q) ##1 wr_ok || mode_q != MODE_SAFETY || $changed(pwe_q))
    else $error("password change not applied");
  AST_RELOAD: assert property (fall |=> tmr_q == $past(cu_q.interval) && !due_q)
    else $error("timer not reloaded");
  AST_DUE: assert property (due_q && !fall |=> due_q)
    else $error("test-due alarm dropped");
  AST_TICK: assert property (tick |=> !tick [*2])
    else $error("monitoring cycle too short");
  AST_VERSION: assert property (rd_i && addr_i == ADDR_VERSION |=> rd_data_o == {PM_VER, CU_VER})
    else $error("version read wrong");

  COV_PARK: cover property (park_q && cut_q && st_q == B_RUN);
  COV_FAULT: cover property (st_q == B_CHK && cu_crc != cref_q);
  COV_PW: cover property (wr_i && addr_i == ADDR_PW_CONFIRM && wr_ok && pwn_q == wdata_i[15:0]);
  COV_DUE: cover property (!due_q ##1 due_q);
endmodule
`default_nettype wire

/* File: verif/dsss_far_model.sv */
// Purpose: Far side model: cutoff select pins and drive enable
// Assumes: Bench raises requests by non-blocking assignment at the edge
// Notes: Skew answers slowly, second channel one clock late
`default_nettype none
module dsss_far_model (
  input wire logic ref_clk_i, // Clock
  input wire logic cut_req_i, // Ask for cutoff
  input wire logic run_req_i, // Ask for drive on
  input wire logic skew_i, // Late power module channel
  output logic sel_cu_n_o, // CU select, low
  output logic sel_pm_n_o, // PM select, low
  output logic drive_on_o // Drive enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic late_q; // Delayed request copy
  // firmware alignment kept on, no pin here
  // selects active low; first edge lands inside reset
  always @(posedge ref_clk_i) begin
    late_q <= cut_req_i;
    sel_cu_n_o <= ~cut_req_i;
    sel_pm_n_o <= skew_i ? ~late_q : ~cut_req_i;
    drive_on_o <= run_req_i;
  end
endmodule
`default_nettype wire

/* File: verif/dsss_top_tb_top.sv */
// Purpose: Self-checking bench of the safe stop supervisor
// Assumes: Shortened tick and hour counts
// Notes: Cutoff waits cover one tick plus sync and model delay
`default_nettype none
module dsss_top_tb_top
  import dsss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MC = 4; // Clocks per tick
  localparam int CT = 3; // Ticks per 0.01 h
  logic ref_clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, chassis_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rd_data_o;
  logic cut_req = 1'b0, run_req = 1'b1, skew = 1'b0;
  logic sel_cu_n, sel_pm_n, drive_on, sd_cu_n, sd_pm_n, lock, brake, due, acc, boot;
  logic [1:0] flt;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  dsss_top #(.MON_CYC(MC), .CH_TICKS(CT)) dsss_top_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .sel_cu_n_i(sel_cu_n), .sel_pm_n_i(sel_pm_n), .drive_on_i(drive_on), .chassis_i(chassis_i),
    .shutdown_cu_n_o(sd_cu_n), .shutdown_pm_n_o(sd_pm_n), .restart_lockout_o(lock),
    .brake_close_o(brake), .test_due_o(due), .cks_fault_o(flt), .accept_test_o(acc), .boot_done_o(boot));
  dsss_far_model dsss_far_model_inst (.ref_clk_i(ref_clk_i), .cut_req_i(cut_req), .run_req_i(run_req),
    .skew_i(skew), .sel_cu_n_o(sel_cu_n), .sel_pm_n_o(sel_pm_n), .drive_on_o(drive_on));
  // Compare helpers, count every check
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // Bus cycles, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, e, rd_data_o & m);
  endtask
  // Request or drop cutoff, then wait out the latency
  task automatic cyc(input logic c);
    @(posedge ref_clk_i);
    cut_req <= c;
    repeat (MC + 5) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic close_out();
    $display("Counts: %0d compares, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic t_boot();
    for (int i = 0; i < 20 && boot !== 1'b1; i++) @(posedge ref_clk_i);
    #1 chk("fault", 32'h3, {30'h0, flt});
    chb("accept", 1'b1, acc);
    chb("boot", 1'b1, boot);
    rd("version", ADDR_VERSION, 32'h0002_0001, '1);
    rd("interval", ADDR_FTI, {12'h0, FTI_DEFAULT}, '1);
    rd("wr gate", ADDR_STATUS, 32'h0, 32'h80);
    chb("cutoff off", 1'b1, sd_cu_n);
    $display("boot test done");
  endtask
  task automatic t_prot();
    wr(ADDR_CU_EN, 32'h1);
    rd("cu_en refused", ADDR_CU_EN, 32'h0, '1);
    rd("rejects", ADDR_STATUS, 32'h0001_0000, 32'h00ff_0000);
    wr(ADDR_MODE, 32'h5f);
    rd("wr_ok", ADDR_STATUS, 32'h80, 32'h80);
    wr(ADDR_CU_EN, 32'h1);
    wr(ADDR_PM_EN, 32'h1);
    rd("pm_en", ADDR_PM_EN, 32'h1, '1);
    wr(ADDR_CMD, 32'h1);
    rd("cu_en", ADDR_CU_EN, 32'h1, '1);
    chk("fault clear", 32'h0, {30'h0, flt});
    chb("accept clear", 1'b0, acc);
    $display("protect test done");
  endtask
  task automatic t_cut();
    cyc(1'b1);
    chb("sd_cu", 1'b0, sd_cu_n);
    chb("sd_pm", 1'b0, sd_pm_n);
    chb("lockout", 1'b1, lock);
    chb("brake", 1'b1, brake);
    rd("status", ADDR_STATUS, 32'h3, 32'h3);
    @(posedge ref_clk_i);
    chassis_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 chb("chassis brake", 1'b0, brake);
    chassis_i <= 1'b0;
    cyc(1'b0);
    chb("sd_pm off", 1'b1, sd_pm_n);
    chb("lock held", 1'b1, lock);
    run_req <= 1'b0;
    cyc(1'b0);
    chb("lock free", 1'b0, lock);
    run_req <= 1'b1;
    wr(ADDR_CTRL, 32'h1);
    cyc(1'b0);
    chb("park", 1'b0, sd_pm_n);
    wr(ADDR_CTRL, 32'h0);
    skew <= 1'b1;
    cyc(1'b1);
    chb("slow pm", 1'b0, sd_cu_n);
    chb("slow pm path", 1'b0, sd_pm_n);
    cyc(1'b0);
    skew <= 1'b0;
    $display("cutoff test done");
  endtask
  task automatic t_timer();
    wr(ADDR_FTI, 32'h000f_ffff);
    rd("fti clip", ADDR_FTI, {12'h0, FTI_MAX}, '1);
    wr(ADDR_FTI, 32'h1);
    cyc(1'b1);
    cyc(1'b0);
    chb("due early", 1'b0, due);
    repeat (10 * MC * CT) @(posedge ref_clk_i);
    #1 chb("due", 1'b1, due);
    chb("runs on", 1'b1, sd_cu_n);
    rd("timer", ADDR_TIMER, 32'h0, '1);
    cyc(1'b1);
    cyc(1'b0);
    chb("due clear", 1'b0, due);
    $display("timer test done");
  endtask
  task automatic t_cmds();
    wr(ADDR_CMD, 32'h2);
    rd("cu_en kept", ADDR_CU_EN, 32'h1, '1);
    wr(ADDR_PW_NEW, 32'h5);
    wr(ADDR_PW_CONFIRM, 32'h5);
    wr(ADDR_PW_ENTRY, 32'h0);
    wr(ADDR_CU_EN, 32'h0);
    rd("old pw", ADDR_CU_EN, 32'h1, '1);
    wr(ADDR_PW_ENTRY, 32'h5);
    wr(ADDR_CU_EN, 32'h0);
    wr(ADDR_PM_EN, 32'h0);
    wr(ADDR_CMD, 32'h4);
    rd("fti reset", ADDR_FTI, {12'h0, FTI_DEFAULT}, '1);
    wr(ADDR_CU_EN, 32'h1);
    wr(ADDR_MODE, 32'h1e5f);
    wr(ADDR_CMD, 32'h8);
    rd("restored", ADDR_CU_EN, 32'h0, '1);
    $display("command test done");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_boot();
    t_prot();
    t_cut();
    t_timer();
    t_cmds();
    close_out();
  end
endmodule
`default_nettype wire
